// File: design/tpe_event_unit.sv
// Event flags, enables and request outputs of a two-unit, twelve-channel timer
// How it works
// - Mode 4: B edge with A level sets direction; A edges never count.
// - Quadrature only on channels 1,2,4,5; pins A/B for 1,5, C/D for 2,4.
// - Wrap while counting up sets overflow; wrap counting down sets underflow.
// - Per channel: match/capture and overflow sources, underflow on 1,2,4,5 only, each flag plus enable.
// - Event sets its flag; request raised while flag and enable both one.
// - Request drops as soon as its flag is cleared.
// - Priority inside a channel is fixed; across channels left outside.
// - Registers A-D on channels 0 and 3, A-B elsewhere: sixteen per unit.
// - Match request when capture or compare sets flag and its enable is one.
// - Every channel has an overflow request, flag and enable gated.
// - Underflow request only on channels 1,2,4,5, flag and enable gated.
// - Only register A match request may start a DMA transfer.
// - Register A flag with converter trigger enable requests a conversion.
// - Only unit 0 may request conversions; unit 1 never does.
// - Unit 1 channels 6-11 mirror the interrupt set of channels 0-5.
// - Small variant: channels 4 and 5 have compare match, no capture.
// - Channel 1 count clock selectable as capture source of channel 0 B.
// - Channel 0 A and C matches selectable to capture channel 1 count.
// - DMA start clears the register A flag and its request.
`timescale 1ns/100ps
`default_nettype none
`include "tpe_defines.svh"
module tpe_event_unit #(
	parameter int NUM_CH = `TPE_NUM_CH,
	parameter bit SMALL_VARIANT = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Phase pins, one per unit
	input wire logic [1:0] ext_clock_pin_a,
	input wire logic [1:0] ext_clock_pin_b,
	input wire logic [1:0] ext_clock_pin_c,
	input wire logic [1:0] ext_clock_pin_d,
	// Timer core events, four registers per channel
	input wire logic [NUM_CH-1:0] cnt_tick,
	input wire logic [NUM_CH*4-1:0] cmp_match,
	input wire logic [NUM_CH*4-1:0] cap_trig,
	// DMA controller
	input wire logic [NUM_CH-1:0] dma_start,
	output logic [NUM_CH-1:0] dma_req,
	// A/D converter, unit 0 only
	output logic [`TPE_CH_PER_UNIT-1:0] adc_req,
	// Interrupt controller
	output logic [NUM_CH*4-1:0] match_capture_irq,
	output logic [NUM_CH-1:0] overflow_irq,
	output logic [NUM_CH-1:0] underflow_irq,
	output logic [NUM_CH*3-1:0] irq_source
);
	// Per channel state
	logic [5:0] flag_r [NUM_CH];
	logic [5:0] armed_r [NUM_CH];
	logic [7:0] ien_r [NUM_CH];
	logic [1:0] ctrl_r [NUM_CH];
	tpe_pkg::tpe_cnt_t cnt_r [NUM_CH];
	logic dir_dn_r [NUM_CH];
	logic [5:0] irq_r [NUM_CH];
	logic [NUM_CH-1:0] dma_r;
	logic [`TPE_CH_PER_UNIT-1:0] adc_r;
	tpe_pkg::tpe_src_t src_r [NUM_CH];
	tpe_pkg::tpe_cnt_t cap_r [4];
	logic [NUM_CH-1:0] cnt_clk;
	logic [31:0] rd_ch [NUM_CH];
	logic [31:0] prdata_r;

	// Bus decode; the slave never stretches, so every access ends in its first access cycle
	logic acc;
	logic wr;
	logic rd;
	logic [3:0] a_ch;
	logic [1:0] a_reg;
	logic ch_hit;
	logic cap_hit;
	logic bad_addr;
	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign a_ch = paddr[7:4];
	assign a_reg = paddr[3:2];
	assign ch_hit = (32'(a_ch) < NUM_CH);
	assign cap_hit = (a_ch == `TPE_CAP_BASE);
	assign bad_addr = (~ch_hit & ~cap_hit) | (paddr[1:0] != 2'h0);
	assign pready = 1'b1;
	assign pslverr = acc & bad_addr;
	assign prdata = prdata_r;

	// Read data registered at the setup-phase edge so the master samples it one edge later
	logic [31:0] rd_mux;
	assign rd_mux = bad_addr ? 32'h0000_0000 :
		cap_hit ? {16'h0000, cap_r[paddr[3:2]]} : rd_ch[a_ch];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_r <= 32'h0000_0000;
		end else if (psel & ~penable & ~pwrite) begin
			prdata_r <= rd_mux;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			localparam int LC = ch % `TPE_CH_PER_UNIT;
			localparam int UN = ch / `TPE_CH_PER_UNIT;
			localparam bit HAS_CD = (LC == 0) || (LC == 3);
			localparam bit HAS_QUAD = !HAS_CD;
			localparam bit HAS_CAP = !(SMALL_VARIANT && (LC >= 4));
			localparam logic [5:0] EXIST = {HAS_QUAD, 1'b1, HAS_CD, HAS_CD, 2'h3};
			localparam logic [7:0] IEN_MASK = {(UN == 0), 1'b0, EXIST};

			logic q_up;
			logic q_dn;
			logic up;
			logic dn;
			logic ovf;
			logic unf;
			logic [3:0] xroute;
			logic [5:0] ev;
			logic [5:0] clr;
			logic [5:0] flag_nxt;
			logic sel_here;
			logic wr_stat;
			logic wr_ien;
			logic wr_ctrl;
			logic wr_cnt;
			tpe_pkg::tpe_src_t src_nxt;

			// Phase pin pairing per channel position
			if (HAS_QUAD) begin : g_quad
				logic pa;
				logic pb;
				assign pa = (LC == 1 || LC == 5) ? ext_clock_pin_a[UN] : ext_clock_pin_c[UN];
				assign pb = (LC == 1 || LC == 5) ? ext_clock_pin_b[UN] : ext_clock_pin_d[UN];
				tpe_quad_dec u_dec (
					.clk(clk),
					.rst_n(rst_n),
					.phase_a(pa),
					.phase_b(pb),
					.cnt_up(q_up),
					.cnt_dn(q_dn)
				);
			end else begin : g_noquad
				assign q_up = 1'b0;
				assign q_dn = 1'b0;
			end

			// Count source: decoder in quadrature mode, core tick otherwise
			assign up = ctrl_r[ch][`TPE_CTRL_QUAD] ? q_up : cnt_tick[ch];
			assign dn = ctrl_r[ch][`TPE_CTRL_QUAD] & q_dn;
			assign cnt_clk[ch] = up | dn;
			assign ovf = up & (cnt_r[ch] == `TPE_CNT_MAX);
			assign unf = dn & (cnt_r[ch] == `TPE_RST_CNT);

			// Cross-channel capture sources
			if (LC == 0) begin : g_x0
				assign xroute = {2'h0, ctrl_r[ch][`TPE_CTRL_CAPSEL] & cnt_clk[ch+1], 1'b0};
			end else if (LC == 1) begin : g_x1
				assign xroute = {2'h0,
					ctrl_r[ch][`TPE_CTRL_CAPSEL] & cmp_match[(ch-1)*4+2],
					ctrl_r[ch][`TPE_CTRL_CAPSEL] & cmp_match[(ch-1)*4]};
				// Latch the up/down count at each control period
				always_ff @(posedge clk or negedge rst_n) begin
					if (!rst_n) begin
						cap_r[UN*2] <= `TPE_RST_CNT;
						cap_r[UN*2+1] <= `TPE_RST_CNT;
					end else begin
						if (xroute[0])
							cap_r[UN*2] <= cnt_r[ch];
						if (xroute[1])
							cap_r[UN*2+1] <= cnt_r[ch];
					end
				end
			end else begin : g_xn
				assign xroute = 4'h0;
			end

			// Event set and clear terms; a set in the clearing cycle wins
			assign ev = EXIST & {unf, ovf,
				cmp_match[ch*4+:4] | (HAS_CAP ? cap_trig[ch*4+:4] : 4'h0) | xroute};
			assign sel_here = ch_hit & (32'(a_ch) == ch) & (paddr[1:0] == 2'h0);
			assign wr_stat = wr & sel_here & (a_reg == `TPE_REG_STAT);
			assign wr_ien = wr & sel_here & (a_reg == `TPE_REG_IEN);
			assign wr_ctrl = wr & sel_here & (a_reg == `TPE_REG_CTRL);
			assign wr_cnt = wr & sel_here & (a_reg == `TPE_REG_CNT);
			assign clr = ({6{wr_stat}} & ~pwdata[5:0] & armed_r[ch])
				| {5'h00, dma_start[ch] & dma_r[ch]};
			assign flag_nxt = (flag_r[ch] & ~clr) | ev;

			// Flags and their read-as-one arming
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					flag_r[ch] <= `TPE_RST_FLAGS;
					armed_r[ch] <= 6'h00;
				end else begin
					flag_r[ch] <= flag_nxt;
					if (rd & sel_here & (a_reg == `TPE_REG_STAT))
						armed_r[ch] <= armed_r[ch] | flag_r[ch];
					else if (wr_stat)
						armed_r[ch] <= 6'h00;
				end
			end

			// Enables, control and counter; bits without a source stay zero
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					ien_r[ch] <= `TPE_RST_IEN;
					ctrl_r[ch] <= `TPE_RST_CTRL;
					cnt_r[ch] <= `TPE_RST_CNT;
					dir_dn_r[ch] <= 1'b0;
				end else begin
					if (wr_ien)
						ien_r[ch] <= pwdata[7:0] & IEN_MASK;
					if (wr_ctrl)
						ctrl_r[ch] <= pwdata[1:0] & {LC <= 1, HAS_QUAD};
					// A bus write beats a count in the same cycle
					if (wr_cnt)
						cnt_r[ch] <= pwdata[15:0];
					else if (up)
						cnt_r[ch] <= cnt_r[ch] + 16'h0001;
					else if (dn)
						cnt_r[ch] <= cnt_r[ch] - 16'h0001;
					if (up | dn)
						dir_dn_r[ch] <= dn;
				end
			end

			// Fixed order inside a channel: A, B, C, D, overflow, underflow
			always_comb begin
				src_nxt = tpe_pkg::TPE_SRC_NONE;
				if (flag_nxt[`TPE_BIT_U] & ien_r[ch][`TPE_BIT_U])
					src_nxt = tpe_pkg::TPE_SRC_U;
				if (flag_nxt[`TPE_BIT_V] & ien_r[ch][`TPE_BIT_V])
					src_nxt = tpe_pkg::TPE_SRC_V;
				if (flag_nxt[`TPE_BIT_D] & ien_r[ch][`TPE_BIT_D])
					src_nxt = tpe_pkg::TPE_SRC_D;
				if (flag_nxt[`TPE_BIT_C] & ien_r[ch][`TPE_BIT_C])
					src_nxt = tpe_pkg::TPE_SRC_C;
				if (flag_nxt[`TPE_BIT_B] & ien_r[ch][`TPE_BIT_B])
					src_nxt = tpe_pkg::TPE_SRC_B;
				if (flag_nxt[`TPE_BIT_A] & ien_r[ch][`TPE_BIT_A])
					src_nxt = tpe_pkg::TPE_SRC_A;
			end

			// Requests follow flag AND enable, registered at the same edge as the flag
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					irq_r[ch] <= 6'h00;
					dma_r[ch] <= 1'b0;
					src_r[ch] <= tpe_pkg::TPE_SRC_NONE;
				end else begin
					irq_r[ch] <= flag_nxt & ien_r[ch][5:0];
					dma_r[ch] <= flag_nxt[`TPE_BIT_A] & ien_r[ch][`TPE_BIT_A];
					src_r[ch] <= src_nxt;
				end
			end

			if (UN == 0) begin : g_adc
				always_ff @(posedge clk or negedge rst_n) begin
					if (!rst_n)
						adc_r[LC] <= 1'b0;
					else
						adc_r[LC] <= flag_nxt[`TPE_BIT_A] & ien_r[ch][`TPE_BIT_ADC];
				end
			end

			// Output and read-back wiring
			assign match_capture_irq[ch*4+:4] = irq_r[ch][3:0];
			assign overflow_irq[ch] = irq_r[ch][`TPE_BIT_V];
			assign underflow_irq[ch] = irq_r[ch][`TPE_BIT_U];
			assign irq_source[ch*3+:3] = src_r[ch];
			assign rd_ch[ch] = (a_reg == `TPE_REG_STAT) ? {25'h0, dir_dn_r[ch], flag_r[ch]} :
				(a_reg == `TPE_REG_IEN) ? {24'h0, ien_r[ch]} :
				(a_reg == `TPE_REG_CTRL) ? {30'h0, ctrl_r[ch]} : {16'h0, cnt_r[ch]};
		end
	endgenerate

	// Unit 1 has no converter path at all
	assign dma_req = dma_r;
	assign adc_req = adc_r;
endmodule
`default_nettype wire

// File: design/tpe_defines.svh
// Register offsets, field positions and reset values of the timer event block
`ifndef TPE_DEFINES_SVH
`define TPE_DEFINES_SVH

// Word index of each register inside a channel window of 16 bytes
`define TPE_REG_STAT 2'h0
`define TPE_REG_IEN 2'h1
`define TPE_REG_CTRL 2'h2
`define TPE_REG_CNT 2'h3

// Channel windows occupy 8'h00..8'hbf, capture latches start here
`define TPE_CAP_BASE 4'hc
`define TPE_NUM_CH 12
`define TPE_CH_PER_UNIT 6

// Flag and enable bit positions
`define TPE_BIT_A 0
`define TPE_BIT_B 1
`define TPE_BIT_C 2
`define TPE_BIT_D 3
`define TPE_BIT_V 4
`define TPE_BIT_U 5
`define TPE_BIT_DIR 6
`define TPE_BIT_ADC 7

// Control bit positions
`define TPE_CTRL_QUAD 0
`define TPE_CTRL_CAPSEL 1

// Reset values
`define TPE_RST_FLAGS 6'h00
`define TPE_RST_IEN 8'h00
`define TPE_RST_CTRL 2'h0
`define TPE_RST_CNT 16'h0000
`define TPE_CNT_MAX 16'hffff

`endif

// File: design/tpe_pkg.sv
// Types shared by the timer event block
package tpe_pkg;
	typedef logic [15:0] tpe_cnt_t;
	// Highest pending source of a channel, fixed order A, B, C, D, overflow, underflow
	typedef enum logic [2:0] {
		TPE_SRC_NONE = 3'h0,
		TPE_SRC_A = 3'h1,
		TPE_SRC_B = 3'h2,
		TPE_SRC_C = 3'h3,
		TPE_SRC_D = 3'h4,
		TPE_SRC_V = 3'h5,
		TPE_SRC_U = 3'h6
	} tpe_src_t;
endpackage

// File: design/tpe_quad_dec.sv
// Two-phase pin synchroniser and up/down decoder for quadrature counting mode 4
`timescale 1ns/100ps
`default_nettype none
module tpe_quad_dec (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Raw phase pins
	input wire logic phase_a,
	input wire logic phase_b,
	// Count pulses
	output logic cnt_up,
	output logic cnt_dn
);
	logic [1:0] a_sync_r;
	logic [1:0] b_sync_r;
	logic b_prev_r;
	logic b_rise;
	logic b_fall;

	// Two stages before any logic looks at the pins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			a_sync_r <= 2'h0;
			b_sync_r <= 2'h0;
			b_prev_r <= 1'b0;
		end else begin
			a_sync_r <= {a_sync_r[0], phase_a};
			b_sync_r <= {b_sync_r[0], phase_b};
			b_prev_r <= b_sync_r[1];
		end
	end

	// Only phase B edges count, phase A level gives the direction
	assign b_rise = b_sync_r[1] & ~b_prev_r;
	assign b_fall = ~b_sync_r[1] & b_prev_r;
	assign cnt_up = (b_rise & a_sync_r[1]) | (b_fall & ~a_sync_r[1]);
	assign cnt_dn = (b_fall & a_sync_r[1]) | (b_rise & ~a_sync_r[1]);
endmodule
`default_nettype wire

// File: bench/tpe_event_monitor.sv
// Port-level assertions for the timer event block
`timescale 1ns/100ps
`default_nettype none
module tpe_event_monitor #(
	parameter int NUM_CH = 12
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// APB request
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	// Events and requests
	input wire logic [NUM_CH*4-1:0] cmp_match,
	input wire logic [NUM_CH*4-1:0] cap_trig,
	input wire logic [NUM_CH-1:0] dma_start,
	input wire logic [NUM_CH-1:0] dma_req,
	input wire logic [NUM_CH*4-1:0] match_capture_irq,
	input wire logic [NUM_CH-1:0] overflow_irq,
	input wire logic [NUM_CH-1:0] underflow_irq,
	input wire logic [NUM_CH*3-1:0] irq_source
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Requests rise only from an event or a register write
	a_rise_cause: assert property ($rose(match_capture_irq[13]) |->
		$past(cmp_match[13] | cap_trig[13] | (psel & penable & pwrite))) else $error("irq rose without cause");
	a_dma_only_a: assert property ($rose(dma_req[0]) |->
		$past(cmp_match[0] | cap_trig[0] | (psel & penable & pwrite))) else $error("dma rose without A event");
	// Requests other than register A fall only by a software write
	a_drop_write: assert property ($fell(match_capture_irq[13]) |->
		$past(psel && penable && pwrite)) else $error("irq fell without write");
	// DMA start clears the request one edge later
	a_dma_clear: assert property (dma_start[0] && dma_req[0] && !cmp_match[0] && !cap_trig[0]
		|=> !dma_req[0]) else $error("dma request not cleared");
	// Missing sources never request
	a_no_cd: assert property ((match_capture_irq & 48'hcc0cc0cc0cc0) == 48'h0)
		else $error("C/D request on two-register channel");
	a_no_unf: assert property ((underflow_irq & 12'h249) == 12'h000)
		else $error("underflow request on channel without one");
	// Fixed order inside a channel
	a_src_none: assert property ((irq_source[2:0] == 3'h0) ==
		!(|match_capture_irq[3:0] || overflow_irq[0])) else $error("source code disagrees");
	a_prio_a: assert property (match_capture_irq[24] |-> irq_source[20:18] == 3'h1)
		else $error("register A not highest");
	c_dma: cover property (dma_start[0] && dma_req[0]);
	c_unf: cover property ($rose(underflow_irq[1]));
	c_ovf: cover property ($rose(overflow_irq[1]));
endmodule
bind tpe_event_unit tpe_event_monitor #(.NUM_CH(NUM_CH)) i_mon (.clk, .rst_n, .psel, .penable, .pwrite,
	.cmp_match, .cap_trig, .dma_start, .dma_req, .match_capture_irq, .overflow_irq, .underflow_irq, .irq_source);
`default_nettype wire

// File: bench/tpe_far_model.sv
// DMA controller and converter trigger model at the far side
`timescale 1ns/100ps
`default_nettype none
module tpe_far_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Requests
	input wire logic [11:0] dma_req,
	input wire logic [5:0] adc_req,
	// Knobs
	input wire logic [3:0] lat,
	input wire logic adc_sel,
	// Answers
	output logic [11:0] dma_start,
	output var int adc_conv
);
	logic [3:0] wait_r;
	logic [5:0] adc_q;
	// Converter counts new requests only when set to accept them
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			adc_q <= 6'h00;
			adc_conv <= 0;
		end else begin
			adc_q <= adc_req;
			if (adc_sel && |(adc_req & ~adc_q))
				adc_conv <= adc_conv + 1;
		end
	end
	// One start pulse lat+1 cycles after the request, repeated lat+2 cycles after each pulse while the request stays high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_r <= 4'h0;
			dma_start <= 12'h000;
		end else begin
			dma_start <= 12'h000;
			if (dma_req == 12'h000 || dma_start != 12'h000)
				wait_r <= 4'h0;
			else if (wait_r >= lat)
				dma_start <= dma_req;
			else
				wait_r <= wait_r + 4'h1;
		end
	end
endmodule
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the timer event block
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [1:0] pa = 2'h0, pb = 2'h0;
	logic [11:0] tick = 12'h0, dma_start, dma_req, ovf, unf;
	logic [47:0] cmp = 48'h0, mci;
	logic [35:0] src;
	logic [5:0] adc;
	logic [3:0] lat = 4'h3;
	int err_total = 0, cmp_count = 0, adc_conv;
	always #12.5 clk = ~clk;
	tpe_event_unit i_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.ext_clock_pin_a(pa), .ext_clock_pin_b(pb), .ext_clock_pin_c(2'h0), .ext_clock_pin_d(2'h0),
		.cnt_tick(tick), .cmp_match(cmp), .cap_trig(48'h0), .dma_start, .dma_req, .adc_req(adc),
		.match_capture_irq(mci), .overflow_irq(ovf), .underflow_irq(unf), .irq_source(src));
	tpe_far_model i_far (.clk, .rst_n, .dma_req, .adc_req(adc), .lat, .adc_sel(1'b1), .dma_start, .adc_conv);
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	// APB cycle, one idle edge after so no strobe is driven twice in a step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One-cycle event pulse, returns once outputs have settled
	task automatic hit(input logic t, input int b);
		if (t) tick[b] <= 1'b1;
		else cmp[b] <= 1'b1;
		@(posedge clk);
		tick <= 12'h0;
		cmp <= 48'h0;
		@(posedge clk);
	endtask
	task automatic end_sim;
		$display("checks %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		err_total++;
		end_sim;
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		apb(0, 8'h34, 0);
		chk("ien3", 32'h0, rd);
		apb(0, 8'hd0, 0);
		chk("slverr", 32'h1, {31'h0, er});
		chk("unmapped", 32'h0, rd);
		$display("test reset done");
		// Channel 3: B then A, fixed order, read-then-write clear
		apb(1, 8'h34, 32'h13);
		hit(0, 13);
		chk("irq3b", 32'h1, mci[13]);
		chk("src3", 32'h2, src[11:9]);
		hit(0, 12);
		chk("src3a", 32'h1, src[11:9]);
		apb(0, 8'h30, 0);
		chk("stat3", 32'h03, rd);
		apb(1, 8'h30, 0);
		chk("irq3", 32'h0, mci[13:12]);
		chk("src3n", 32'h0, src[11:9]);
		$display("test match done");
		// Channel 0 wrap while counting up; an unarmed write keeps the flag
		apb(1, 8'h04, 32'h10);
		apb(1, 8'h0c, 32'hffff);
		hit(1, 0);
		chk("ovf0", 32'h1, ovf[0]);
		chk("dma0", 32'h0, dma_req[0]);
		apb(1, 8'h00, 0);
		chk("ovfkeep", 32'h1, ovf[0]);
		apb(0, 8'h0c, 0);
		chk("cnt0", 32'h0, rd);
		$display("test overflow done");
		// Channel 1 on pins A/B: B rises with A low, A alone, B falls with A low
		apb(1, 8'h18, 32'h1);
		apb(1, 8'h14, 32'h30);
		pb <= 2'h1;
		wt(6);
		chk("unf1", 32'h1, unf[1]);
		apb(0, 8'h10, 0);
		chk("stat1", 32'h60, rd);
		pa <= 2'h1;
		wt(6);
		apb(0, 8'h1c, 0);
		chk("cnt1", 32'hffff, rd);
		// A falls alone, then B falls with A low: counts up from 0xffff and wraps
		pa <= 2'h0;
		wt(6);
		chk("irq1a", 32'h0, mci[5:4]);
		pb <= 2'h0;
		wt(6);
		chk("ovf1", 32'h1, ovf[1]);
		$display("test quadrature done");
		// Register A on channels 0 and 6 with a slow DMA answer, then channel 0 alone with a prompt one
		apb(1, 8'h04, 32'h81);
		apb(1, 8'h64, 32'h81);
		apb(0, 8'h64, 0);
		chk("ien6", 32'h01, rd);
		cmp <= 48'h000001000001;
		@(posedge clk);
		cmp <= 48'h0;
		@(posedge clk);
		chk("adc", 32'h01, adc);
		chk("dma", 32'h041, dma_req);
		wt(6);
		chk("dmaclr", 32'h0, dma_req);
		chk("irqclr", 32'h0, {mci[24], mci[0]});
		chk("conv", 32'h1, adc_conv);
		lat <= 4'h0;
		hit(0, 0);
		wt(2);
		chk("dmafast", 32'h0, {adc[0], dma_req[0]});
		chk("conv2", 32'h2, adc_conv);
		$display("test dma done");
		// Channel 0 register A match latches the channel 1 count and sets its flag A
		apb(1, 8'h18, 32'h3);
		apb(1, 8'h1c, 32'h1234);
		hit(0, 0);
		wt(2);
		apb(0, 8'hc0, 0);
		chk("cap1", 32'h1234, rd);
		apb(0, 8'h10, 0);
		chk("stat1a", 32'h31, rd);
		$display("test capture done");
		end_sim;
	end
endmodule
`default_nettype wire
